// [include/tdm_host_pkg.sv]
/*
 * Constants, field layout and types for the TDM host controller.
 * Assumes a 10 MHz pclk and a 32-bit APB with word-aligned registers.
 */
`default_nettype none
package tdm_host_pkg;
    // Clock and link timing.
    localparam int          PCLK_PERIOD_NS  = 100;
    localparam int          HALF_BIT_NS     = 400;
    localparam int          HALF_BIT_CYCLES = (HALF_BIT_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
    localparam logic [7:0]  DIV_RESET       = 8'(HALF_BIT_CYCLES);
    localparam logic [7:0]  DIV_MIN         = 8'h03;

    // Register byte offsets.
    localparam logic [11:0] OFF_CTRL        = 12'h000;
    localparam logic [11:0] OFF_CLKDIV      = 12'h004;
    localparam logic [11:0] OFF_STATUS      = 12'h008;
    localparam logic [11:0] OFF_SLOT_INDEX  = 12'h00c;
    localparam logic [11:0] OFF_TX_DATA     = 12'h010;
    localparam logic [11:0] OFF_RX_DATA     = 12'h014;

    // Control register fields.
    localparam int          CTRL_RUN_BIT    = 0;
    localparam int          CTRL_DOUBLE_BIT = 1;
    localparam int          CTRL_PDN_BIT    = 2;
    localparam int          CTRL_LEN_LSB    = 4;
    localparam int          CTRL_SLOT16_BIT = 8;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;

    // Status register fields.
    localparam int          STAT_RUN_BIT    = 0;
    localparam int          STAT_DONE_BIT   = 1;
    localparam int          STAT_CNT_LSB    = 8;

    // Slot geometry.
    localparam int          SLOT_W          = 32;
    localparam int          SLOT_AW         = 4;
    localparam int          SLOT_DEPTH      = 16;
    localparam logic [8:0]  LAST_BIT_8      = 9'h0ff;
    localparam logic [8:0]  LAST_BIT_16     = 9'h1ff;

    // Controller states, Gray coded.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01
    } state_t;

    // Sample length in bits for each length code.
    function automatic logic [5:0] len_of(input logic [1:0] code);
        case (code)
            2'b00:   len_of = 6'h10;
            2'b01:   len_of = 6'h12;
            2'b10:   len_of = 6'h14;
            default: len_of = 6'h18;
        endcase
    endfunction

    // Mask that keeps the left-aligned sample and zeros the pad.
    function automatic logic [31:0] mask_of(input logic [1:0] code);
        case (code)
            2'b00:   mask_of = 32'hffff_0000;
            2'b01:   mask_of = 32'hffff_c000;
            2'b10:   mask_of = 32'hffff_f000;
            default: mask_of = 32'hffff_ff00;
        endcase
    endfunction
endpackage
`default_nettype wire

// [include/slot_mem_if.sv]
/*
 * One write port and one registered read port of a slot memory.
 * Assumes both users run on the same clock as the memory.
 */
`timescale 1ns/1ps
`default_nettype none
interface slot_mem_if;
    logic        we;     // Write strobe.
    logic [3:0]  waddr;  // Write slot index.
    logic [31:0] wdata;  // Write word.
    logic [3:0]  raddr;  // Read slot index.
    logic [31:0] rdata;  // Registered read word.

    modport writer (output we, output waddr, output wdata);
    modport reader (output raddr, input rdata);
    modport mem    (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// [logic/slot_mem.sv]
/*
 * Sixteen-word slot memory with a registered read.
 * Assumes the reader tolerates one cycle of read latency.
 */
`timescale 1ns/1ps
`default_nettype none
module slot_mem
    import tdm_host_pkg::*;
(
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Memory port.
    slot_mem_if.mem   port
);
    logic [SLOT_W-1:0] words [SLOT_DEPTH];  // Storage, not reset.

    // Writes land at the rising edge of the strobe cycle.
    always_ff @(posedge clk)
    begin
        if (port.we)
        begin
            words[port.waddr] <= port.wdata;
        end
    end

    // Read data comes from a register so the path stays short.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port.rdata <= 32'h0000_0000;
        end
        else
        begin
            port.rdata <= words[port.raddr];
        end
    end
endmodule // slot_mem
`default_nettype wire

// [logic/bit_clock_gen.sv]
/*
 * Divides pclk into the link bit clock and marks its edges.
 * Assumes half_div is at least three; the caller clamps it.
 */
`timescale 1ns/1ps
`default_nettype none
module bit_clock_gen
(
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control.
    input  wire logic       run,
    input  wire logic [7:0] half_div,
    // Link clock and edge enables.
    output logic            bit_clock,
    output logic            rise_en,
    output logic            fall_en
);
    logic [7:0] count;  // Cycles into the current half period.
    logic       tick;   // Last cycle of a half period.

    assign tick    = run && (count == 8'(half_div - 8'h01));
    assign rise_en = tick && !bit_clock;
    assign fall_en = tick && bit_clock;

    // Half-period counter; it parks at zero while stopped.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 8'h00;
        end
        else if (!run || tick)
        begin
            count <= 8'h00;
        end
        else
        begin
            count <= 8'(count + 8'h01);
        end
    end

    // The clock idles low, so the first event after start is a rise.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_clock <= 1'b0;
        end
        else if (!run)
        begin
            bit_clock <= 1'b0;
        end
        else if (tick)
        begin
            bit_clock <= !bit_clock;
        end
    end
endmodule // bit_clock_gen
`default_nettype wire

// [logic/tdm_host.sv]
/*
 * Host controller that masters a TDM serial audio link toward a codec
 * running as a slave. Software sets it up and moves slot words over APB.
 * Assumes the codec itself is configured for slave TDM by other means.
 */
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
// Functional notes
// R1: Speed mode selects single or double rate.
// R2: Clocking changes only while converters powered down.
// R3: Master clock is integer multiple of frame.
// R4: Device PLL runs for 256x or 384x.
// R5: Device master mode drives 64x bit clock.
// R6: Device master mode never offers TDM.
// R7: Device master mode master clock ratios.
// R8: 128x and 192x never used with TDM.
// R9: Host drives frame and bit clocks synchronously.
// R10: Non-TDM slave bit clock ratio limits.
// R11: TDM slave ratios: 256x single, 256x/512x double.
// R12: Bit clock never faster than master clock.
// R13: Launch on falling, sample on rising edge.
// R14: MSB first, second rise after frame.
// R15: 32-bit slots, sample left-aligned, zero padded.
// R16: Frame pulse rises, held one bit period.
// R17: Sixteen slots at 512 bits per frame.
// R18: Eight slots at 256 bits per frame.
// R19: Device second output unused in TDM.
// R20: Device measures master clock per frame.
// R21: Device output slots valid from frame start.
`timescale 1ns/1ps
`default_nettype none
module tdm_host
    import tdm_host_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link toward the codec.
    output logic             master_clock,
    output logic             bit_clock,
    output logic             frame_sync_clock,
    output logic [1:0]       serial_input_lines,
    input  wire logic        first_serial_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    state_t       state;         // Controller state.
    logic         ctrl_run;      // Software asks for a running link.
    logic         ctrl_double;   // Double-speed setting.
    logic         ctrl_pdn;      // Software confirms all converters are down.
    logic [1:0]   ctrl_len;      // Sample length code.
    logic         ctrl_slot16;   // Sixteen-slot frame requested.
    logic         slot16;        // Sixteen slots actually in use.
    logic [7:0]   half_div;      // Bit clock half period in pclk cycles.
    logic [3:0]   slot_index;    // Slot pointer for data access.
    logic         frame_done;    // Sticky frame completion flag.
    logic [7:0]   frame_count;   // Completed frames, wrapping.
    logic [8:0]   bit_idx;       // Index of the bit now on the line.
    logic [8:0]   next_idx;      // Index launched at the next fall.
    logic [8:0]   last_bit;      // Final bit index of a frame.
    logic [31:0]  tx_shift;      // Outgoing slot bits.
    logic [31:0]  tx_word;       // Masked word for the next slot.
    logic [31:0]  rx_shift;      // Incoming slot bits.
    logic         rx_sync1;      // First synchroniser stage.
    logic         rx_bit;        // Synchronised device output.
    logic         rise_en;       // Bit clock is about to rise.
    logic         fall_en;       // Bit clock is about to fall.
    logic         running;       // Link clocks are active.
    logic         wr;            // APB write access this cycle.
    logic         setup_rd;      // APB read setup cycle.
    logic         mapped;        // Address hits a register.
    logic         frame_end;     // Last bit of a frame is sampled.
    logic [31:0]  next_prdata;   // Read mux output.

    slot_mem_if tx_port ();
    slot_mem_if rx_port ();

    assign running  = (state == ST_RUN);
    assign wr       = psel && penable && pwrite && mapped;
    assign setup_rd = psel && !penable && !pwrite;
    assign mapped   = (paddr == OFF_CTRL) || (paddr == OFF_CLKDIV) ||
                      (paddr == OFF_STATUS) || (paddr == OFF_SLOT_INDEX) ||
                      (paddr == OFF_TX_DATA) || (paddr == OFF_RX_DATA);
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;

    // Single speed only carries 256 bits per frame, so sixteen slots need double.
    assign slot16   = ctrl_slot16 && ctrl_double;  // R11 R17 R18
    assign last_bit = slot16 ? LAST_BIT_16 : LAST_BIT_8;  // R8 R10
    assign next_idx = (bit_idx == last_bit) ? 9'h000 : 9'(bit_idx + 9'h001);
    assign tx_word  = tx_port.rdata & mask_of(ctrl_len);  // R15
    assign frame_end = rise_en && running && (bit_idx == last_bit);

    // The master clock is the bit clock itself: ratio 256x or 512x, never slower.
    assign master_clock = bit_clock;  // R3 R12

    bit_clock_gen u_clk (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (running),
        .half_div  (half_div),
        .bit_clock (bit_clock),
        .rise_en   (rise_en),
        .fall_en   (fall_en)
    );

    slot_mem u_tx_mem (
        .clk   (pclk),
        .rst_n (presetn),
        .port  (tx_port.mem)
    );

    slot_mem u_rx_mem (
        .clk   (pclk),
        .rst_n (presetn),
        .port  (rx_port.mem)
    );

    // Software fills the transmit slots; the serializer prefetches the next one.
    assign tx_port.we    = wr && (paddr == OFF_TX_DATA);
    assign tx_port.waddr = slot_index;
    assign tx_port.wdata = pwdata;
    assign tx_port.raddr = next_idx[8:5];

    // A received slot is stored when its last bit is sampled.
    assign rx_port.we    = rise_en && running && (bit_idx[4:0] == 5'h1f);
    assign rx_port.waddr = bit_idx[8:5];
    assign rx_port.wdata = {rx_shift[30:0], rx_bit} & mask_of(ctrl_len);  // R15
    assign rx_port.raddr = slot_index;

    // Control register. Clocking fields move only while converters are down;
    // otherwise the codec would mute, so such writes are silently dropped.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_run    <= CTRL_RESET[CTRL_RUN_BIT];
            ctrl_double <= CTRL_RESET[CTRL_DOUBLE_BIT];
            ctrl_pdn    <= CTRL_RESET[CTRL_PDN_BIT];
            ctrl_len    <= CTRL_RESET[CTRL_LEN_LSB +: 2];
            ctrl_slot16 <= CTRL_RESET[CTRL_SLOT16_BIT];
        end
        else if (wr && (paddr == OFF_CTRL))
        begin
            ctrl_pdn <= pwdata[CTRL_PDN_BIT];
            ctrl_len <= running ? ctrl_len : pwdata[CTRL_LEN_LSB +: 2];  // R15
            if (ctrl_pdn)  // R2
            begin
                ctrl_run    <= pwdata[CTRL_RUN_BIT];
                ctrl_double <= pwdata[CTRL_DOUBLE_BIT];  // R1
                ctrl_slot16 <= pwdata[CTRL_SLOT16_BIT];
            end
        end
    end

    // Bit clock divider, clamped so the synchroniser still meets the data eye.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            half_div <= DIV_RESET;
        end
        else if (wr && (paddr == OFF_CLKDIV) && ctrl_pdn)  // R2
        begin
            half_div <= (pwdata[7:0] < DIV_MIN) ? DIV_MIN : pwdata[7:0];
        end
    end

    // Slot pointer used by both data windows.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slot_index <= 4'h0;
        end
        else if (wr && (paddr == OFF_SLOT_INDEX))
        begin
            slot_index <= pwdata[3:0];
        end
    end

    // Frame flag: a frame ending in the clearing cycle keeps it set.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_done  <= 1'b0;
            frame_count <= 8'h00;
        end
        else if (frame_end)
        begin
            frame_done  <= 1'b1;
            frame_count <= 8'(frame_count + 8'h01);
        end
        else if (wr && (paddr == OFF_STATUS) && pwdata[STAT_DONE_BIT])
        begin
            frame_done <= 1'b0;
        end
    end

    // Read data is captured in the setup cycle and held through the access.
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        case (paddr)
            OFF_CTRL:
            begin
                next_prdata[CTRL_RUN_BIT]       = ctrl_run;
                next_prdata[CTRL_DOUBLE_BIT]    = ctrl_double;
                next_prdata[CTRL_PDN_BIT]       = ctrl_pdn;
                next_prdata[CTRL_LEN_LSB +: 2]  = ctrl_len;
                next_prdata[CTRL_SLOT16_BIT]    = ctrl_slot16;
            end
            OFF_CLKDIV:     next_prdata[7:0] = half_div;
            OFF_STATUS:
            begin
                next_prdata[STAT_RUN_BIT]       = running;
                next_prdata[STAT_DONE_BIT]      = frame_done;
                next_prdata[STAT_CNT_LSB +: 8]  = frame_count;
            end
            OFF_SLOT_INDEX: next_prdata[3:0] = slot_index;
            OFF_RX_DATA:    next_prdata = rx_port.rdata;
            default:        next_prdata = 32'h0000_0000;
        endcase
    end

    // Read data register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (setup_rd)
        begin
            prdata <= next_prdata;
        end
    end

    // State machine. The codec is a slave here, which is the only side TDM allows.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            case (state)
                ST_IDLE: if (ctrl_run) state <= ST_RUN;  // R6 R9
                ST_RUN:  if (!ctrl_run) state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Serializer. Frame pulse goes out with the last bit of the previous frame,
    // so the codec sees it one rise before the first MSB.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_idx            <= 9'h000;
            frame_sync_clock   <= 1'b0;
            serial_input_lines <= 2'b00;
            tx_shift           <= 32'h0000_0000;
        end
        else if (!running)
        begin
            bit_idx            <= 9'(last_bit - 9'h001);
            frame_sync_clock   <= 1'b0;
            serial_input_lines <= 2'b00;
            tx_shift           <= 32'h0000_0000;
        end
        else if (fall_en)  // R13
        begin
            bit_idx          <= next_idx;
            frame_sync_clock <= (next_idx == last_bit);  // R16
            if (next_idx[4:0] == 5'h00)  // R14
            begin
                serial_input_lines[0] <= tx_word[31];
                tx_shift              <= {tx_word[30:0], 1'b0};
            end
            else
            begin
                serial_input_lines[0] <= tx_shift[31];
                tx_shift              <= {tx_shift[30:0], 1'b0};
            end
        end
    end

    // Two-stage synchroniser for the codec output.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_sync1 <= 1'b0;
            rx_bit   <= 1'b0;
        end
        else
        begin
            rx_sync1 <= first_serial_output;
            rx_bit   <= rx_sync1;
        end
    end

    // Deserializer samples at the rising bit clock, MSB first.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_shift <= 32'h0000_0000;
        end
        else if (rise_en && running)  // R13 R14
        begin
            rx_shift <= {rx_shift[30:0], rx_bit};
        end
    end

    sequence fs_launch;
        fall_en && frame_sync_clock;
    endsequence

    sequence msb_slot0;
        (bit_idx == 9'h000) && !frame_sync_clock;
    endsequence

    fs_one_bit_a: assert property (fs_launch |=> msb_slot0)  // R14 R16
        else $error("frame pulse not followed by slot 0 MSB");
    fs_on_fall_a: assert property ($rose(frame_sync_clock) |-> $fell(bit_clock))  // R13
        else $error("frame pulse did not rise with bit clock fall");
    data_on_fall_a: assert property (running && $changed(serial_input_lines[0])
                                     |-> $fell(bit_clock))  // R13
        else $error("data changed off the falling bit clock");
    pad_zero_a: assert property (running && $fell(bit_clock) &&
                                 (6'(bit_idx[4:0]) >= len_of(ctrl_len))
                                 |-> !serial_input_lines[0])  // R15
        else $error("pad bit not zero");
    ratio_tdm_a: assert property (running && !ctrl_double |-> (last_bit == LAST_BIT_8))  // R11
        else $error("single speed used a 512 bit frame");
    mclk_ratio_a: assert property ($rose(bit_clock) |-> $rose(master_clock))  // R3 R12
        else $error("master clock not aligned to bit clock");
    cfg_hold_a: assert property (!ctrl_pdn |=> $stable({ctrl_run, ctrl_double,
                                                        ctrl_slot16, half_div}))  // R2
        else $error("clocking changed while converters powered");
    rx_store_a: assert property (rx_port.we |-> rise_en && running &&
                                 (bit_idx[4:0] == 5'h1f))  // R13
        else $error("receive slot stored off a slot boundary");
    done_set_a: assert property (frame_end |=> frame_done)
        else $error("frame flag not set at frame end");
endmodule // tdm_host
`default_nettype wire

// [bench/tdm_codec_model.sv]
/*
 * Behavioural codec slave on the TDM link: it captures host slots and sends its own.
 * Assumes the host masters bit and frame clocks, with frames of 256 or 512 bits.
 */
`timescale 1ns/1ps
`default_nettype none
module tdm_codec_model
(
    // Link from the host.
    input  wire logic master_clock,
    input  wire logic bit_clock,
    input  wire logic frame_sync_clock,
    input  wire logic serial_in,
    // Link toward the host.
    output logic      serial_out,
    output wire logic second_out
);
    logic [31:0] rx_slot [16]; // Words captured from the host.
    logic [31:0] tx_word;      // Word being sent in the current slot.
    logic [9:0]  rx_pos;       // Bit position in the frame, all ones when idle.
    logic [9:0]  tx_pos;       // Next bit to launch, all ones when idle.
    logic        fs_seen;      // Frame level at the previous bit-clock rise.
    logic        fs_mc;        // Frame level at the previous master-clock rise.
    int          mclk_count;   // Master clocks since the last frame start.
    int          ratio;        // Master clocks in the last whole frame.

    // The spare output floats, so nothing downstream may read it as data.
    assign second_out = 1'bz;

    // Start idle; the first frame pulse brings both counters into step.
    initial
    begin
        rx_pos = 10'h3ff;
        tx_pos = 10'h3ff;
        fs_seen = 1'b0;
        fs_mc = 1'b0;
        serial_out = 1'b0;
        mclk_count = 0;
        ratio = 0;
    end

    // Master clocks per frame give the ratio that the host must keep integral.
    always @(posedge master_clock)
    begin
        mclk_count <= (frame_sync_clock && !fs_mc) ? 1 : mclk_count + 1;
        if (frame_sync_clock && !fs_mc)
            ratio <= mclk_count;
        fs_mc <= frame_sync_clock;
    end

    // Sample on the rise; the frame pulse seen here puts the MSB at the next rise.
    always @(posedge bit_clock)
    begin
        if (rx_pos != 10'h3ff)
        begin
            rx_slot[rx_pos[8:5]][~rx_pos[4:0]] <= serial_in;
            rx_pos <= (rx_pos == 10'h1ff) ? 10'h3ff : rx_pos + 10'h001;
        end
        if (frame_sync_clock && !fs_seen)
        begin
            rx_pos <= 10'h000;
            tx_pos <= 10'h000;
        end
        fs_seen <= frame_sync_clock;
    end

    // Launch on the fall; an idle line toggles so stale data never looks valid.
    always @(negedge bit_clock)
    begin
        tx_word = {tx_pos[8:5], 20'h9a5c3, 8'h00};
        if (tx_pos == 10'h3ff)
            serial_out <= ~serial_out;
        else
        begin
            serial_out <= tx_word[~tx_pos[4:0]];
            tx_pos <= (tx_pos == 10'h1ff) ? 10'h3ff : tx_pos + 10'h001;
        end
    end
endmodule // tdm_codec_model
`default_nettype wire

// [bench/tdm_host_test.sv]
/*
 * Self-checking bench for the TDM host; tests drive APB calls and also check the link pins and codec model directly.
 * Assumes the codec model on the link and a 10 MHz pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module tdm_host_test
    import tdm_host_pkg::*;
();
    logic        pclk;                    // Bus clock.
    logic        presetn;                 // Bus reset, active low.
    logic        psel, penable, pwrite;   // Bus controls.
    logic [11:0] paddr;                   // Bus address.
    logic [31:0] pwdata, prdata;          // Bus data.
    logic        pready, pslverr;         // Bus answer.
    logic        master_clock, bit_clock; // Link clocks.
    logic        frame_sync_clock;        // Frame pulse.
    logic [1:0]  serial_input_lines;      // Data toward the codec.
    logic        first_serial_output;     // Data from the codec.
    wire         second_line;             // Floating spare codec output.
    int          fail_count;              // Mismatches seen.
    int          samples_checked;         // Comparisons made.
    logic [31:0] cfg [5] = '{32'h005, 32'h017, 32'h025, 32'h035, 32'h137}; // Runs.

    tdm_host i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .master_clock(master_clock),
        .bit_clock(bit_clock), .frame_sync_clock(frame_sync_clock),
        .serial_input_lines(serial_input_lines), .first_serial_output(first_serial_output));
    tdm_codec_model i_codec (.master_clock(master_clock), .bit_clock(bit_clock),
        .frame_sync_clock(frame_sync_clock), .serial_in(serial_input_lines[0]),
        .serial_out(first_serial_output), .second_out(second_line));

    // Free-running bus clock.
    always #50 pclk = ~pclk;

    // Every comparison lands here so the tally stays in one place.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; an idle edge after release keeps back-to-back calls clean.
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 64)
        begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, pready}, 32'h0000_0001);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Register write.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(a, 1'b1, d, r, e);
    endtask

    // Register read against an expected word and error flag.
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic        e;
        xfer(a, 1'b0, 32'h0000_0000, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, err});
    endtask

    // Clear the frame flag and poll until a frame ends; polls are bounded.
    task automatic wait_frame();
        logic [31:0] r;
        logic        e;
        wr(OFF_STATUS, 32'h0000_0002);
        r = 32'h0000_0000;
        for (int n = 0; n < 3000 && r[STAT_DONE_BIT] !== 1'b1; n++)
            xfer(OFF_STATUS, 1'b0, 32'h0000_0000, r, e);
        chk({31'h0, r[STAT_DONE_BIT]}, 32'h0000_0001);
    endtask

    // Wait out the start-up frame end and one whole frame in one setting, then compare both directions slot by slot.
    task automatic run_cfg(input logic [31:0] ctrl);
        logic [31:0] r;
        logic [31:0] mask;
        logic        e;
        int          slots;
        int          len;
        slots = ctrl[CTRL_SLOT16_BIT] ? 16 : 8;
        len = (ctrl[5:4] == 2'b11) ? 24 : 16 + 2 * ctrl[5:4];
        mask = ~(32'hffff_ffff >> len);
        wr(OFF_CTRL, ctrl);
        wait_frame();
        wait_frame();
        xfer(OFF_STATUS, 1'b0, 32'h0000_0000, r, e);
        chk({31'h0, r[STAT_RUN_BIT]}, 32'h0000_0001);
        chk({30'h0, master_clock ^ bit_clock, serial_input_lines[1]}, 32'h0000_0000);
        for (int n = 0; n < slots; n++)
        begin
            wr(OFF_SLOT_INDEX, 32'(n));
            rd(OFF_RX_DATA, {4'(n), 20'h9a5c3, 8'h00} & mask, 1'b0);
            chk(i_codec.rx_slot[n], {4'(n), 28'hace_1357} & mask);
        end
        chk(32'(i_codec.ratio), 32'(slots * 32));
        wr(OFF_CTRL, 32'h0000_0004);
    endtask

    // Single place where the run ends.
    task automatic finish_test();
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence: reset, register checks, then every run setting in turn.
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL, CTRL_RESET, 1'b0);
        rd(OFF_CLKDIV, 32'(DIV_RESET), 1'b0);
        rd(OFF_STATUS, 32'h0000_0000, 1'b0);
        rd(12'h018, 32'h0000_0000, 1'b1);
        wr(OFF_CTRL, 32'h0000_0001);
        rd(OFF_CTRL, 32'h0000_0000, 1'b0);
        wr(OFF_CTRL, 32'h0000_0004);
        wr(OFF_CLKDIV, 32'h0000_0001);
        rd(OFF_CLKDIV, 32'(DIV_MIN), 1'b0);
        wr(OFF_CLKDIV, 32'(DIV_RESET));
        for (int n = 0; n < 16; n++)
        begin
            wr(OFF_SLOT_INDEX, 32'(n));
            wr(OFF_TX_DATA, {4'(n), 28'hace_1357});
        end
        rd(OFF_TX_DATA, 32'h0000_0000, 1'b0);
        foreach (cfg[i])
            run_cfg(cfg[i]);
        finish_test();
    end

    // Watchdog, sized well beyond the five runs.
    initial
    begin
        #(9_000_000);
        fail_count++;
        finish_test();
    end
endmodule // tdm_host_test
`default_nettype wire
